// ### rtl/sdram_cmd_defs.svh
// constants for the two-bank synchronous dram command block
// assumes inclusion by bare name from rtl files
`ifndef SDRAM_CMD_DEFS_SVH
`define SDRAM_CMD_DEFS_SVH

// =====================================
// pin positions and mode word reset value
`define BANK_SEL_BIT 11
`define AUTO_CLOSE_BIT 10
`define MODE_WORD_RST 12'h0000

// =====================================
// timing in clock cycles
`define CAS_LAT_CYC 3
`define RC_CYC 9
`define BURST_LEN_DEF 4
`define SELF_REF_INTERVAL_CYC 625

`endif

// ### rtl/sdram_cmd_pkg.sv
// types for the dram command block
// assumes the defs header is available
package sdram_cmd_pkg;
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_MODE = 4'h1,
        CMD_REFRESH = 4'h2,
        CMD_CLOSE = 4'h3,
        CMD_OPEN = 4'h4,
        CMD_WRITE = 4'h5,
        CMD_READ = 4'h6,
        CMD_HALT = 4'h7
    } cmd_type;

    typedef enum logic [4:0] {
        ST_RUN = 5'b0_0001,
        ST_AREF = 5'b0_0010,
        ST_SELF = 5'b0_0100,
        ST_PDOWN = 5'b0_1000,
        ST_SUSP = 5'b1_0000
    } state_type;
endpackage

// ### rtl/cmd_bus_if.sv
// decoded command bundle passed from the decoder to the core
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface cmd_bus_if;
    sdram_cmd_pkg::cmd_type cmd;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic gate_now;
    logic gate_prev;
    modport src (output cmd, output addr, output wdata, output gate_now, output gate_prev);
    modport dst (input cmd, input addr, input wdata, input gate_now, input gate_prev);
endinterface
`default_nettype wire

// ### rtl/cmd_decode.sv
// pin synchroniser and command decoder
// assumes pins arrive asynchronously to clk_in
`timescale 1ns/1ps
`default_nettype none
module cmd_decode (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // pins
    input wire logic chip_sel_n_in,
    input wire logic row_strobe_n_in,
    input wire logic col_strobe_n_in,
    input wire logic write_strobe_n_in,
    input wire logic clk_gate_in,
    input wire logic [11:0] addr_in,
    input wire logic [15:0] dq_in,
    // decoded
    cmd_bus_if.src cb
);
    // =====================================
    // two stage synchroniser
    logic [32:0] s1_q;
    logic [32:0] s2_q;
    logic gate_prev_q;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s1_q <= '0;
            s2_q <= '0;
            gate_prev_q <= 1'b0;
        end else begin
            s1_q <= {clk_gate_in, chip_sel_n_in, row_strobe_n_in, col_strobe_n_in,
                     write_strobe_n_in, addr_in, dq_in};
            s2_q <= s1_q;
            gate_prev_q <= s2_q[32];
        end
    end

    // =====================================
    // decode, only while gate was high the cycle before
    always_comb begin
        cb.cmd = sdram_cmd_pkg::CMD_NONE;
        if (gate_prev_q && !s2_q[31]) begin
            case (s2_q[30:28])
                3'b000: cb.cmd = sdram_cmd_pkg::CMD_MODE;
                3'b001: cb.cmd = sdram_cmd_pkg::CMD_REFRESH;
                3'b010: cb.cmd = sdram_cmd_pkg::CMD_CLOSE;
                3'b011: cb.cmd = sdram_cmd_pkg::CMD_OPEN;
                3'b100: cb.cmd = sdram_cmd_pkg::CMD_WRITE;
                3'b101: cb.cmd = sdram_cmd_pkg::CMD_READ;
                3'b110: cb.cmd = sdram_cmd_pkg::CMD_HALT;
                default: cb.cmd = sdram_cmd_pkg::CMD_NONE;
            endcase
        end
    end
    assign cb.addr = s2_q[27:16];
    assign cb.wdata = s2_q[15:0];
    assign cb.gate_now = s2_q[32];
    assign cb.gate_prev = gate_prev_q;
endmodule
`default_nettype wire

// ### rtl/refresh_addr_gen.sv
// internal refresh row and bank counter
// assumes one step pulse per refresh
`timescale 1ns/1ps
`default_nettype none
module refresh_addr_gen #(
    parameter int ROWS = 4096
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // control
    input wire logic step_in,
    output logic [$clog2(ROWS):0] addr_out
);
    // =====================================
    // bank in top bit, row below
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            addr_out <= '0;
        end else if (step_in) begin
            addr_out <= addr_out + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### rtl/sdram_cmd_core.sv
// two-bank synchronous dram command engine, device side
// assumes commands obey the controller timing; no software registers
//
// Operation
// - mode word load captures all twelve address pins into the mode register
// - open selects bank by bit 11 and row by bits 0 to 10
// - close with bit 10 high closes both banks, else bit 11 bank
// - read bursts from bank bit 11, column bits 0 to 9, after latency
// - read with bit 10 high closes the bank after the burst
// - write bursts at column, bit 10 high closes bank after burst
// - auto refresh uses internal row and bank, then returns idle
// - self refresh runs while gate low, internally timed, ends on rise
// - burst halt ends bursts; read data stops after latency
// - idle command or unselect leaves state unchanged
// - power down while gate low ignores pins, ends on rise
// - suspend freezes a burst while gate low, keeps all state
`timescale 1ns/1ps
`default_nettype none
`include "sdram_cmd_defs.svh"
module sdram_cmd_core #(
    parameter int BURST_LEN = `BURST_LEN_DEF,
    parameter int CAS_LAT = `CAS_LAT_CYC,
    parameter int SELF_INTERVAL = `SELF_REF_INTERVAL_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // command pins
    input wire logic chip_sel_n_in,
    input wire logic row_strobe_n_in,
    input wire logic col_strobe_n_in,
    input wire logic write_strobe_n_in,
    input wire logic clk_gate_in,
    input wire logic [11:0] addr_in,
    // data pins
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic dq_oe_n_out,
    // status
    output logic [11:0] mode_word_out,
    output logic [1:0] bank_open_out,
    output logic [4:0] state_out,
    output logic [12:0] refresh_addr_out
);
    cmd_bus_if cb ();
    sdram_cmd_pkg::state_type st_q;
    logic [10:0] row_q [2];
    logic [1:0] open_q;
    logic [11:0] mode_q;
    logic rd_act_q;
    logic wr_act_q;
    logic bank_q;
    logic close_after_q;
    logic [9:0] col_q;
    logic [7:0] beat_q;
    logic [CAS_LAT-1:0] pipe_v_q;
    logic [15:0] pipe_d_q [CAS_LAT];
    logic [3:0] rc_cnt_q;
    logic [15:0] self_cnt_q;
    logic ref_step;
    logic [11:0] ref_addr;
    logic [15:0] mem_q [0:255];
    logic run;
    logic burst_end;
    logic halt_now;

    // =====================================
    // submodules
    cmd_decode u_dec (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .chip_sel_n_in(chip_sel_n_in),
        .row_strobe_n_in(row_strobe_n_in),
        .col_strobe_n_in(col_strobe_n_in),
        .write_strobe_n_in(write_strobe_n_in),
        .clk_gate_in(clk_gate_in),
        .addr_in(addr_in),
        .dq_in(dq_in),
        .cb(cb)
    );

    refresh_addr_gen #(.ROWS(2048)) u_ref (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .step_in(ref_step),
        .addr_out(ref_addr)
    );

    // suspend freezes everything but the gate watcher
    assign run = (st_q == sdram_cmd_pkg::ST_RUN);
    assign halt_now = run && cb.cmd == sdram_cmd_pkg::CMD_HALT;
    assign burst_end = (rd_act_q || wr_act_q) && beat_q == 8'(BURST_LEN - 1);
    assign ref_step = (run && cb.cmd == sdram_cmd_pkg::CMD_REFRESH)
        || (st_q == sdram_cmd_pkg::ST_SELF && self_cnt_q == 16'(SELF_INTERVAL - 1));

    // =====================================
    // power state machine
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_q <= sdram_cmd_pkg::ST_RUN;
        end else begin
            case (st_q)
                sdram_cmd_pkg::ST_RUN: begin
                    if (cb.cmd == sdram_cmd_pkg::CMD_REFRESH) begin
                        // gate low on the refresh edge selects self refresh
                        st_q <= cb.gate_now ? sdram_cmd_pkg::ST_AREF
                                            : sdram_cmd_pkg::ST_SELF;
                    end else if (cb.gate_prev && !cb.gate_now) begin
                        st_q <= (rd_act_q || wr_act_q) ? sdram_cmd_pkg::ST_SUSP
                                                       : sdram_cmd_pkg::ST_PDOWN;
                    end
                end
                sdram_cmd_pkg::ST_AREF: begin
                    if (rc_cnt_q == 4'(`RC_CYC - 2)) begin
                        st_q <= sdram_cmd_pkg::ST_RUN;
                    end
                end
                sdram_cmd_pkg::ST_SELF,
                sdram_cmd_pkg::ST_PDOWN,
                sdram_cmd_pkg::ST_SUSP: begin
                    if (cb.gate_now) begin
                        st_q <= sdram_cmd_pkg::ST_RUN;
                    end
                end
                default: st_q <= sdram_cmd_pkg::ST_RUN;
            endcase
        end
    end

    // =====================================
    // internal refresh timers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rc_cnt_q <= 4'h0;
        end else if (st_q == sdram_cmd_pkg::ST_AREF) begin
            rc_cnt_q <= rc_cnt_q + 4'h1;
        end else begin
            rc_cnt_q <= 4'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            self_cnt_q <= 16'h0000;
        end else if (st_q == sdram_cmd_pkg::ST_SELF && !ref_step) begin
            self_cnt_q <= self_cnt_q + 16'h0001;
        end else begin
            self_cnt_q <= 16'h0000;
        end
    end

    // =====================================
    // mode register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mode_q <= `MODE_WORD_RST;
        end else if (run && cb.cmd == sdram_cmd_pkg::CMD_MODE) begin
            mode_q <= cb.addr;
        end
    end

    // =====================================
    // bank rows, opened and closed
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            open_q <= 2'b00;
            row_q[0] <= 11'h000;
            row_q[1] <= 11'h000;
        end else if (run) begin
            if (cb.cmd == sdram_cmd_pkg::CMD_OPEN) begin
                open_q[cb.addr[`BANK_SEL_BIT]] <= 1'b1;
                row_q[cb.addr[`BANK_SEL_BIT]] <= cb.addr[10:0];
            end else if (cb.cmd == sdram_cmd_pkg::CMD_CLOSE) begin
                if (cb.addr[`AUTO_CLOSE_BIT]) begin
                    open_q <= 2'b00;
                end else begin
                    open_q[cb.addr[`BANK_SEL_BIT]] <= 1'b0;
                end
            end else if (burst_end && close_after_q) begin
                open_q[bank_q] <= 1'b0;
            end
        end
    end

    // =====================================
    // burst engine; a new column command restarts the burst
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            bank_q <= 1'b0;
            close_after_q <= 1'b0;
            col_q <= 10'h000;
            beat_q <= 8'h00;
        end else if (run) begin
            if (cb.cmd == sdram_cmd_pkg::CMD_READ || cb.cmd == sdram_cmd_pkg::CMD_WRITE) begin
                rd_act_q <= cb.cmd == sdram_cmd_pkg::CMD_READ;
                wr_act_q <= cb.cmd == sdram_cmd_pkg::CMD_WRITE;
                bank_q <= cb.addr[`BANK_SEL_BIT];
                close_after_q <= cb.addr[`AUTO_CLOSE_BIT];
                col_q <= cb.addr[9:0] + 10'h001;
                beat_q <= 8'h01;
            end else if (halt_now || burst_end) begin
                rd_act_q <= 1'b0;
                wr_act_q <= 1'b0;
                beat_q <= 8'h00;
            end else if (rd_act_q || wr_act_q) begin
                col_q <= col_q + 10'h001;
                beat_q <= beat_q + 8'h01;
            end
        end
    end

    // =====================================
    // storage; small array keyed by bank and low column bits only
    always_ff @(posedge clk_in) begin
        if (run && cb.cmd == sdram_cmd_pkg::CMD_WRITE) begin
            mem_q[{cb.addr[`BANK_SEL_BIT], cb.addr[6:0]}] <= cb.wdata;
        end else if (run && wr_act_q && !halt_now) begin
            // the last beat still stores its word; burst_end only stops the engine after it
            mem_q[{bank_q, col_q[6:0]}] <= cb.wdata;
        end
    end

    // =====================================
    // read latency pipe; halt stops feeding, tail drains over latency
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pipe_v_q <= '0;
        end else if (run) begin
            pipe_v_q[0] <= (cb.cmd == sdram_cmd_pkg::CMD_READ)
                || (rd_act_q && !halt_now
                    && cb.cmd != sdram_cmd_pkg::CMD_WRITE);
            pipe_v_q[CAS_LAT-1:1] <= pipe_v_q[CAS_LAT-2:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (run) begin
            pipe_d_q[0] <= (cb.cmd == sdram_cmd_pkg::CMD_READ)
                ? mem_q[{cb.addr[`BANK_SEL_BIT], cb.addr[6:0]}]
                : mem_q[{bank_q, col_q[6:0]}];
        end
    end

    for (genvar i = 1; i < CAS_LAT; i++) begin : g_pipe
        always_ff @(posedge clk_in) begin
            if (run) begin
                pipe_d_q[i] <= pipe_d_q[i-1];
            end
        end
    end

    // =====================================
    // registered outputs
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            dq_out <= 16'h0000;
            dq_oe_n_out <= 1'b1;
            mode_word_out <= `MODE_WORD_RST;
            bank_open_out <= 2'b00;
            state_out <= 5'b0_0001;
            refresh_addr_out <= 13'h0000;
        end else begin
            if (run) begin
                dq_out <= pipe_d_q[CAS_LAT-1];
                dq_oe_n_out <= !pipe_v_q[CAS_LAT-1];
            end
            mode_word_out <= mode_q;
            bank_open_out <= open_q;
            state_out <= st_q;
            refresh_addr_out <= {1'b0, ref_addr};
        end
    end
endmodule
`default_nettype wire

// ### sim/sdram_cmd_checker.sv
// assertions on the pins of the dram command block
// assumes a bind to sdram_cmd_core, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // command pins
    input wire logic chip_sel_n_in,
    input wire logic row_strobe_n_in,
    input wire logic col_strobe_n_in,
    input wire logic write_strobe_n_in,
    input wire logic clk_gate_in,
    input wire logic [11:0] addr_in,
    // outputs
    input wire logic [15:0] dq_out,
    input wire logic dq_oe_n_out,
    input wire logic [11:0] mode_word_out,
    input wire logic [1:0] bank_open_out,
    input wire logic [4:0] state_out
);
    // ==========
    // decode helpers
    logic [3:0] pins;
    logic gate_q;
    logic ok;
    logic [11:0] cap_q;
    assign pins = {chip_sel_n_in, row_strobe_n_in, col_strobe_n_in, write_strobe_n_in};
    assign ok = clk_gate_in && gate_q && state_out == 5'h01;
    always_ff @(posedge clk_in) begin
        gate_q <= clk_gate_in;
    end
    // only mode and open addresses are kept; idle cycles must not overwrite them
    always_ff @(posedge clk_in) begin
        if (ok && (pins == 4'h0 || pins == 4'h3)) begin
            cap_q <= addr_in;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // ==========
    // properties
    AST_MODE_LOAD: assert property (ok && pins == 4'h0 |-> ##[2:4] mode_word_out == cap_q)
        else $error("mode word not loaded");
    AST_OPEN_BANK: assert property (ok && pins == 4'h3 |-> ##[2:4] bank_open_out[cap_q[11]])
        else $error("bank not opened");
    AST_CLOSE_ALL: assert property (ok && pins == 4'h2 && addr_in[10] |->
        ##[2:4] bank_open_out == 2'b00)
        else $error("banks not closed");
    AST_READ_LAT: assert property (ok && pins == 4'h5 |-> ##[6:7] !dq_oe_n_out)
        else $error("read data late");
    AST_HALT_STOP: assert property (ok && pins == 4'h6 |-> ##[5:7] dq_oe_n_out)
        else $error("burst not halted");
    AST_REFRESH: assert property (ok && pins == 4'h1 |->
        ##[2:4] state_out == 5'h02 ##[1:12] state_out == 5'h01)
        else $error("refresh did not finish");
    AST_SELF_IN: assert property (gate_q && !clk_gate_in && state_out == 5'h01 && pins == 4'h1
        |-> ##[2:4] state_out == 5'h04)
        else $error("self refresh not entered");
    AST_SELF_OUT: assert property (state_out == 5'h04 && clk_gate_in |->
        ##[1:4] state_out == 5'h01)
        else $error("self refresh not left");
    AST_GATE_IGNORE: assert property (!clk_gate_in [*6] |->
        $stable(mode_word_out) && $stable(bank_open_out))
        else $error("pins acted on while gated");
    AST_SUSP_HOLD: assert property (state_out == 5'h10 && $past(state_out) == 5'h10 |->
        $stable(dq_out) && $stable(dq_oe_n_out))
        else $error("suspend lost data");
endmodule
bind sdram_cmd_core sdram_cmd_checker u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .chip_sel_n_in(chip_sel_n_in), .row_strobe_n_in(row_strobe_n_in),
    .col_strobe_n_in(col_strobe_n_in), .write_strobe_n_in(write_strobe_n_in),
    .clk_gate_in(clk_gate_in), .addr_in(addr_in), .dq_out(dq_out), .dq_oe_n_out(dq_oe_n_out),
    .mode_word_out(mode_word_out), .bank_open_out(bank_open_out), .state_out(state_out));
`default_nettype wire

// ### sim/sdram_ctrl_model.sv
// memory controller model driving the command pins
// assumes its tasks are called one at a time from the bench
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model (
    // clock
    input wire logic clk_in,
    // pins
    output logic [3:0] pins_out,
    output logic gate_out,
    output logic [11:0] addr_out,
    output logic [15:0] data_out
);
    initial begin
        pins_out = 4'hf;
        gate_out = 1'b1;
        addr_out = 12'h000;
        data_out = 16'h0000;
    end
    // ==========
    // one command then idle; gap is the wait the controller owes
    task automatic cmd(input logic [3:0] p, input logic [11:0] a, input logic g, input int gap);
        @(posedge clk_in);
        pins_out <= p;
        addr_out <= a;
        gate_out <= g;
        @(posedge clk_in);
        pins_out <= 4'h7;
        addr_out <= ~a;
        repeat (gap) @(posedge clk_in);
        #1;
    endtask
    // ==========
    // first word with the command, one word a cycle after
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk_in);
        pins_out <= 4'h4;
        addr_out <= a;
        data_out <= d;
        for (int k = 1; k < 4; k++) begin
            @(posedge clk_in);
            pins_out <= 4'h7;
            data_out <= d + 16'(k);
        end
        @(posedge clk_in);
        data_out <= ~(d + 16'h0003);
        repeat (10) @(posedge clk_in); // recovery before close, open or refresh
        #1;
    endtask
endmodule
`default_nettype wire

// ### sim/sdram_two_bank_command_set_test.sv
// self-checking bench for the dram command block
// assumes the controller model keeps every controller wait
`timescale 1ns/1ps
`default_nettype none
module sdram_two_bank_command_set_test;
    // ==========
    // clock, pins, counters
    logic clk_in;
    logic sys_rst_in;
    wire logic [3:0] pins;
    wire logic gate;
    wire logic [11:0] addr;
    wire logic [15:0] wdata;
    logic [15:0] dq_out;
    logic dq_oe_n_out;
    logic [11:0] mode_word_out;
    logic [1:0] bank_open_out;
    logic [4:0] state_out;
    logic [12:0] refresh_addr_out;
    int fail_count = 0;
    int n_checks = 0;
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    sdram_ctrl_model u_ctrl (.clk_in(clk_in), .pins_out(pins), .gate_out(gate),
        .addr_out(addr), .data_out(wdata));
    // short self refresh interval keeps the run brief
    sdram_cmd_core #(.SELF_INTERVAL(8)) u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .chip_sel_n_in(pins[3]), .row_strobe_n_in(pins[2]), .col_strobe_n_in(pins[1]),
        .write_strobe_n_in(pins[0]), .clk_gate_in(gate), .addr_in(addr), .dq_in(wdata),
        .dq_out(dq_out), .dq_oe_n_out(dq_oe_n_out), .mode_word_out(mode_word_out),
        .bank_open_out(bank_open_out), .state_out(state_out),
        .refresh_addr_out(refresh_addr_out));
    // ==========
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_st(input logic [4:0] s);
        for (int i = 0; i < 60; i++) begin
            @(posedge clk_in);
            #1;
            if (state_out === s) return;
        end
        fail_count++;
        $display("Error %0t: state wait timed out", $time);
        stop_test();
    endtask
    // md 0 plain, 1 halt, 2 suspend mid-burst; frozen repeats are not counted
    task automatic rd(input logic [11:0] a, input logic [15:0] d0, input int md,
                      output int n, output int lat, output logic sus);
        logic [15:0] prev;
        n = 0;
        lat = 0;
        sus = 1'b0;
        prev = 16'h0000;
        fork
            begin
                u_ctrl.cmd(4'h5, a, 1'b1, (md == 2) ? 1 : 0);
                if (md == 1) u_ctrl.cmd(4'h6, 12'h000, 1'b1, 0);
                if (md == 2) u_ctrl.cmd(4'h7, 12'h000, 1'b0, 5);
                if (md == 2) u_ctrl.cmd(4'h7, 12'h000, 1'b1, 0);
            end
            begin
                @(posedge clk_in);
                for (int i = 1; i < 30; i++) begin
                    @(posedge clk_in);
                    #1;
                    if (state_out === 5'h10) sus = 1'b1;
                    if (dq_oe_n_out === 1'b0 && (n == 0 || dq_out !== prev)) begin
                        if (n == 0) lat = i;
                        chk(dq_out, d0 + 16'(n));
                        prev = dq_out;
                        n++;
                    end
                end
            end
        join
    endtask
    // ==========
    // scenarios
    task automatic t_mode;
        logic [11:0] w [2] = '{12'ha5c, 12'h5a3};
        #1;
        chk(16'(state_out), 16'h0001);
        for (int i = 0; i < 2; i++) begin
            u_ctrl.cmd(4'h0, w[i], 1'b1, 3); // banks idle
            chk(16'(mode_word_out), 16'(w[i]));
        end
        $display("test mode done");
    endtask
    task automatic t_rw;
        int n;
        int lat;
        logic s;
        u_ctrl.cmd(4'h3, 12'h97f, 1'b1, 10);
        chk(16'(bank_open_out), 16'h0002);
        u_ctrl.cmd(4'h3, 12'h123, 1'b1, 10);
        chk(16'(bank_open_out), 16'h0003);
        u_ctrl.cmd(4'h2, 12'h000, 1'b1, 10);
        chk(16'(bank_open_out), 16'h0002);
        u_ctrl.wr(12'h808, 16'h1234);
        rd(12'h808, 16'h1234, 0, n, lat, s);
        chk(16'(n), 16'h0004);
        chk(16'(lat), 16'h0006);
        rd(12'hc08, 16'h1234, 0, n, lat, s);
        chk(16'(bank_open_out), 16'h0000);
        u_ctrl.cmd(4'h3, 12'h001, 1'b1, 10);
        u_ctrl.wr(12'h410, 16'h5670);
        chk(16'(bank_open_out), 16'h0000);
        u_ctrl.cmd(4'h3, 12'h001, 1'b1, 10);
        u_ctrl.cmd(4'h3, 12'h801, 1'b1, 10);
        rd(12'h010, 16'h5670, 0, n, lat, s);
        chk(16'(n), 16'h0004);
        u_ctrl.cmd(4'h2, 12'h400, 1'b1, 10);
        chk(16'(bank_open_out), 16'h0000);
        $display("test read write done");
    endtask
    task automatic t_gate;
        int n;
        int lat;
        logic s;
        u_ctrl.cmd(4'h3, 12'h800, 1'b1, 10);
        rd(12'h808, 16'h1234, 1, n, lat, s);
        chk(16'(n > 0 && n < 4), 16'h0001);
        rd(12'h808, 16'h1234, 2, n, lat, s);
        chk(16'(n), 16'h0004);
        chk(16'(s), 16'h0001);
        u_ctrl.cmd(4'h7, 12'h000, 1'b0, 0);
        wait_st(5'h08);
        u_ctrl.cmd(4'h2, 12'h400, 1'b0, 3);
        chk(16'(bank_open_out), 16'h0002);
        u_ctrl.cmd(4'h7, 12'h000, 1'b1, 0); // short stay
        wait_st(5'h01);
        u_ctrl.cmd(4'h2, 12'h400, 1'b1, 10);
        $display("test gate done");
    endtask
    task automatic t_refresh;
        logic [12:0] prev;
        prev = refresh_addr_out;
        u_ctrl.cmd(4'h1, 12'h000, 1'b1, 0); // banks idle
        wait_st(5'h02);
        wait_st(5'h01);
        chk(16'(refresh_addr_out), 16'(prev + 13'h0001));
        repeat (9) @(posedge clk_in);
        prev = refresh_addr_out;
        u_ctrl.cmd(4'h1, 12'h000, 1'b0, 0);
        wait_st(5'h04);
        u_ctrl.cmd(4'h0, 12'hfff, 1'b0, 40);
        chk(16'(mode_word_out), 16'h05a3);
        chk(16'(refresh_addr_out !== prev), 16'h0001);
        u_ctrl.cmd(4'h7, 12'h000, 1'b1, 0);
        wait_st(5'h01);
        repeat (9) @(posedge clk_in);
        $display("test refresh done");
    endtask
    initial begin
        sys_rst_in = 1'b1;
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_mode();
        t_rw();
        t_gate();
        t_refresh();
        stop_test();
    end
endmodule
`default_nettype wire
